// ---- src/cbcr_top.sv ----
module cbcr_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic [2:0] address_select_pin,
    input wire logic sideband_enable_pin,
    input wire logic [19:0] sb_disable,
    output logic [19:0] sb_allow,
    output logic [4:0] imp_trim_down,
    output logic [4:0] imp_trim_up
);
    typedef struct packed {
        cbcr_pkg::cbcr_state_t st;
        cbcr_pkg::cbcr_state_t nxt;
        logic scl;
        logic sda;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic bdone;
        logic [7:0] ptr;
        logic [7:0] wrem;
        logic [4:0] rrem;
        logic d_phase;
        logic [2:0] sel;
        logic sel_ok;
        logic wr_en;
        logic [7:0] wr_idx;
        logic [7:0] wr_data;
        logic oe_n;
        logic sda_o;
    } cbcr_main_t;

    cbcr_main_t s_q, s_d;
    logic [7:0] rd_data;
    logic [4:0] read_len;
    logic rise, fall, start, stop;

    cbcr_regs u_regs (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(s_q.wr_en),
        .wr_idx(s_q.wr_idx),
        .wr_data(s_q.wr_data),
        .rd_idx(s_q.ptr),
        .rd_data(rd_data),
        .sideband_enable_pin(sideband_enable_pin),
        .sb_disable(sb_disable),
        .read_len(read_len),
        .sb_allow(sb_allow),
        .imp_trim_down(imp_trim_down),
        .imp_trim_up(imp_trim_up)
    );

    ////////////////////////////////////////////////////////////////
    // bus pins are synchronous, so one stage of history is enough for edges
    assign rise = !s_q.scl && scl_i;
    assign fall = s_q.scl && !scl_i;
    assign start = s_q.scl && scl_i && s_q.sda && !sda_i;
    assign stop = s_q.scl && scl_i && !s_q.sda && sda_i;

    always_comb begin
        logic [7:0] tx_byte;
        // count byte first, then register data prefetched at ptr
        tx_byte = s_q.d_phase ? rd_data : {3'h0, s_q.rrem};
        s_d = s_q;
        s_d.scl = scl_i;
        s_d.sda = sda_i;
        s_d.wr_en = 1'b0;
        s_d.sda_o = 1'b0;
        if (!s_q.sel_ok) begin
            s_d.sel = address_select_pin;
            s_d.sel_ok = 1'b1;
        end
        if (start) begin
            s_d.st = cbcr_pkg::ST_ADDR;
            s_d.bitc = 3'h0;
            s_d.bdone = 1'b0;
            s_d.oe_n = 1'b1;
        end else if (stop) begin
            s_d.st = cbcr_pkg::ST_IDLE;
            s_d.oe_n = 1'b1;
        end else begin
            case (s_q.st)
                cbcr_pkg::ST_ADDR, cbcr_pkg::ST_CMD, cbcr_pkg::ST_CNT, cbcr_pkg::ST_WDATA: begin
                    if (rise) begin
                        s_d.sh = {s_q.sh[6:0], sda_i};
                        s_d.bitc = s_q.bitc + 3'h1;
                        s_d.bdone = (s_q.bitc == cbcr_pkg::BIT_LAST);
                    end else if (fall && s_q.bdone) begin
                        s_d.st = cbcr_pkg::ST_ACK;
                        s_d.oe_n = 1'b0;
                        case (s_q.st)
                            cbcr_pkg::ST_ADDR: begin
                                if (s_q.sh[7:1] == {cbcr_pkg::ADDR_UPPER, s_q.sel}) begin
                                    s_d.nxt = s_q.sh[0] ? cbcr_pkg::ST_TX : cbcr_pkg::ST_CMD;
                                    // length snapshot: a new value counts from the next read
                                    s_d.rrem = read_len;
                                    s_d.d_phase = 1'b0;
                                end else begin
                                    s_d.st = cbcr_pkg::ST_IGNORE;
                                    s_d.oe_n = 1'b1;
                                end
                            end
                            cbcr_pkg::ST_CMD: begin
                                s_d.ptr = s_q.sh;
                                s_d.nxt = cbcr_pkg::ST_CNT;
                            end
                            cbcr_pkg::ST_CNT: begin
                                s_d.wrem = s_q.sh;
                                s_d.nxt = cbcr_pkg::ST_WDATA;
                            end
                            default: begin
                                if (s_q.wrem != 8'h00) begin
                                    // each whole byte lands at once, so a cut-short block keeps it
                                    s_d.wr_en = 1'b1;
                                    s_d.wr_idx = s_q.ptr;
                                    s_d.wr_data = s_q.sh;
                                    s_d.ptr = s_q.ptr + 8'h01;
                                    s_d.wrem = s_q.wrem - 8'h01;
                                    s_d.nxt = cbcr_pkg::ST_WDATA;
                                end else begin
                                    s_d.st = cbcr_pkg::ST_IGNORE;
                                    s_d.oe_n = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                cbcr_pkg::ST_ACK: begin
                    if (fall) begin
                        s_d.st = s_q.nxt;
                        s_d.bitc = 3'h0;
                        s_d.bdone = 1'b0;
                        s_d.oe_n = 1'b1;
                        if (s_q.nxt == cbcr_pkg::ST_TX) begin
                            s_d.sh = tx_byte;
                            s_d.oe_n = tx_byte[7];
                        end
                    end
                end
                cbcr_pkg::ST_TX: begin
                    if (rise) begin
                        s_d.bitc = s_q.bitc + 3'h1;
                        s_d.bdone = (s_q.bitc == cbcr_pkg::BIT_LAST);
                    end else if (fall) begin
                        if (s_q.bdone) begin
                            s_d.st = cbcr_pkg::ST_MACK;
                            s_d.oe_n = 1'b1;
                            s_d.bdone = 1'b0;
                        end else begin
                            s_d.sh = {s_q.sh[6:0], 1'b0};
                            s_d.oe_n = s_q.sh[6];
                        end
                    end
                end
                cbcr_pkg::ST_MACK: begin
                    if (rise) begin
                        // stop on a nack, or after exactly the programmed count even if acked
                        if (!sda_i && (s_q.d_phase ? s_q.rrem != 5'h01 : s_q.rrem != 5'h00)) begin
                            if (s_q.d_phase) begin
                                s_d.ptr = s_q.ptr + 8'h01;
                                s_d.rrem = s_q.rrem - 5'h01;
                            end
                            s_d.d_phase = 1'b1;
                        end else begin
                            s_d.st = cbcr_pkg::ST_IGNORE;
                        end
                    end else if (fall) begin
                        // needs scl high for two mclk so the prefetch settles
                        s_d.st = cbcr_pkg::ST_TX;
                        s_d.bitc = 3'h0;
                        s_d.sh = tx_byte;
                        s_d.oe_n = tx_byte[7];
                    end
                end
                default: begin
                    s_d.oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= cbcr_pkg::ST_IDLE;
            s_q.nxt <= cbcr_pkg::ST_IDLE;
            s_q.scl <= 1'b1;
            s_q.sda <= 1'b1;
            s_q.oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_oe_n = s_q.oe_n;
    assign sda_o = s_q.sda_o;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_strap_latch: assert property ($rose(s_q.sel_ok) |-> s_q.sel == $past(address_select_pin))
        else $error("address select not latched");
    a_addr_match: assert property (s_q.st == cbcr_pkg::ST_ADDR && fall && s_q.bdone && !start && !stop
        && s_q.sh[7:1] == {cbcr_pkg::ADDR_UPPER, s_q.sel} |=> s_q.st == cbcr_pkg::ST_ACK && !sda_oe_n)
        else $error("own address not acknowledged");
    a_addr_foreign: assert property (s_q.st == cbcr_pkg::ST_ADDR && fall && s_q.bdone && !start && !stop
        && s_q.sh[7:1] != {cbcr_pkg::ADDR_UPPER, s_q.sel} |=> s_q.st == cbcr_pkg::ST_IGNORE && sda_oe_n)
        else $error("foreign address acknowledged");
    a_byte_write: assert property (s_q.st == cbcr_pkg::ST_WDATA && fall && s_q.bdone && !start && !stop
        && s_q.wrem != 8'h00 |=> s_q.wr_en && s_q.wr_idx == $past(s_q.ptr) ##1 !s_q.wr_en)
        else $error("received byte not written");
    a_read_stop: assert property (s_q.st == cbcr_pkg::ST_MACK && s_q.d_phase && s_q.rrem == 5'h01 && rise
        && !start && !stop |=> s_q.st == cbcr_pkg::ST_IGNORE && sda_oe_n)
        else $error("read ran past byte count");
    a_len_snap: assert property (s_q.st == cbcr_pkg::ST_ACK && s_q.nxt == cbcr_pkg::ST_TX && !s_q.d_phase
        && fall && !start && !stop |=> s_q.sh == {3'h0, $past(read_len)})
        else $error("count byte not the length");
    a_ack_hold: assert property (s_q.st == cbcr_pkg::ST_ACK && !fall && !start && !stop |=> !sda_oe_n)
        else $error("ack released early");

    c_block_write: cover property (s_q.wr_en ##[1:1000] s_q.wr_en);
    c_block_read: cover property (s_q.st == cbcr_pkg::ST_MACK && s_q.d_phase ##[1:1000] s_q.st == cbcr_pkg::ST_IGNORE);
    c_foreign: cover property (s_q.st == cbcr_pkg::ST_ADDR ##1 s_q.st == cbcr_pkg::ST_IGNORE);
endmodule // cbcr_top

// ---- src/cbcr_pkg.sv ----
package cbcr_pkg;
    localparam logic [3:0] ADDR_UPPER = 4'hd;
    localparam logic [7:0] IDX_LEN = 8'h07;
    localparam logic [7:0] IDX_OVR_LO = 8'h08;
    localparam logic [7:0] IDX_OVR_MID = 8'h09;
    localparam logic [7:0] IDX_OVR_HI = 8'h0a;
    localparam logic [7:0] IDX_IMP_TOP = 8'h0b;
    localparam logic [7:0] IDX_IMP_NEXT = 8'h0c;
    localparam logic [4:0] LEN_RESET = 5'h08;
    localparam logic [7:0] LEN_MASK = 8'h1f;
    localparam logic [7:0] OVR_HI_MASK = 8'h0f;
    localparam logic [7:0] IMP_TOP_MASK = 8'hdb;
    localparam logic [7:0] IMP_NEXT_MASK = 8'h6c;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int IMP19_LSB = 6;
    localparam int IMP18_LSB = 3;
    localparam int IMP17_LSB = 0;
    localparam int IMP16_LSB = 5;
    localparam int IMP15_LSB = 2;
    localparam int IMP_OUTS = 5;
    localparam int OUTS = 20;
    localparam logic [1:0] IMP_LOWER = 2'h1;
    localparam logic [1:0] IMP_HIGHER = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_CNT,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } cbcr_state_t;
endpackage

// ---- src/cbcr_regs.sv ----
module cbcr_regs (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [7:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_idx,
    output logic [7:0] rd_data,
    input wire logic sideband_enable_pin,
    input wire logic [19:0] sb_disable,
    output logic [4:0] read_len,
    output logic [19:0] sb_allow,
    output logic [4:0] imp_trim_down,
    output logic [4:0] imp_trim_up
);
    typedef struct packed {
        logic [4:0] len;
        logic [19:0] ovr;
        logic [9:0] imp;
        logic [7:0] rdata;
        logic [19:0] allow;
        logic [4:0] down;
        logic [4:0] up;
    } cbcr_regs_t;

    cbcr_regs_t r_q, r_d;

    // returns {higher, lower}; 00 and 11 both mean nominal
    function automatic logic [1:0] imp_dir(input logic [1:0] code);
        return {code == cbcr_pkg::IMP_HIGHER, code == cbcr_pkg::IMP_LOWER};
    endfunction

    always_comb begin
        logic [7:0] v;
        logic [1:0] dir;
        v = cbcr_pkg::BYTE_ZERO;
        dir = 2'h0;
        r_d = r_q;
        if (wr_en) begin
            if (wr_idx == cbcr_pkg::IDX_LEN) begin
                r_d.len = wr_data[4:0];
            end else if (wr_idx == cbcr_pkg::IDX_OVR_LO) begin
                r_d.ovr[7:0] = wr_data;
            end else if (wr_idx == cbcr_pkg::IDX_OVR_MID) begin
                r_d.ovr[15:8] = wr_data;
            end else if (wr_idx == cbcr_pkg::IDX_OVR_HI) begin
                r_d.ovr[19:16] = wr_data[3:0];
            end else if (wr_idx == cbcr_pkg::IDX_IMP_TOP) begin
                r_d.imp[9:8] = wr_data[cbcr_pkg::IMP19_LSB +: 2];
                r_d.imp[7:6] = wr_data[cbcr_pkg::IMP18_LSB +: 2];
                r_d.imp[5:4] = wr_data[cbcr_pkg::IMP17_LSB +: 2];
            end else if (wr_idx == cbcr_pkg::IDX_IMP_NEXT) begin
                r_d.imp[3:2] = wr_data[cbcr_pkg::IMP16_LSB +: 2];
                r_d.imp[1:0] = wr_data[cbcr_pkg::IMP15_LSB +: 2];
            end
        end
        // unmapped indices read as zero, writes to them are dropped
        if (rd_idx == cbcr_pkg::IDX_LEN) begin
            v[4:0] = r_q.len;
        end else if (rd_idx == cbcr_pkg::IDX_OVR_LO) begin
            v = r_q.ovr[7:0];
        end else if (rd_idx == cbcr_pkg::IDX_OVR_MID) begin
            v = r_q.ovr[15:8];
        end else if (rd_idx == cbcr_pkg::IDX_OVR_HI) begin
            v[3:0] = r_q.ovr[19:16];
        end else if (rd_idx == cbcr_pkg::IDX_IMP_TOP) begin
            v[cbcr_pkg::IMP19_LSB +: 2] = r_q.imp[9:8];
            v[cbcr_pkg::IMP18_LSB +: 2] = r_q.imp[7:6];
            v[cbcr_pkg::IMP17_LSB +: 2] = r_q.imp[5:4];
        end else if (rd_idx == cbcr_pkg::IDX_IMP_NEXT) begin
            v[cbcr_pkg::IMP16_LSB +: 2] = r_q.imp[3:2];
            v[cbcr_pkg::IMP15_LSB +: 2] = r_q.imp[1:0];
        end
        r_d.rdata = v;
        // masks only count while the side-band interface is enabled
        r_d.allow = ~sb_disable | (sideband_enable_pin ? r_q.ovr : '0);
        for (int i = 0; i < cbcr_pkg::IMP_OUTS; i++) begin
            dir = imp_dir(r_q.imp[2*i +: 2]);
            r_d.down[i] = dir[0];
            r_d.up[i] = dir[1];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '0;
            r_q.len <= cbcr_pkg::LEN_RESET;
            r_q.allow <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    assign rd_data = r_q.rdata;
    assign read_len = r_q.len;
    assign sb_allow = r_q.allow;
    assign imp_trim_down = r_q.down;
    assign imp_trim_up = r_q.up;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_len_write: assert property (wr_en && wr_idx == cbcr_pkg::IDX_LEN |=> r_q.len == $past(wr_data[4:0]))
        else $error("length field not updated");
    a_len_resv: assert property (rd_idx == cbcr_pkg::IDX_LEN |=> (rd_data & ~cbcr_pkg::LEN_MASK) == 8'h00)
        else $error("length reserved bits not zero");
    a_hi_mask_map: assert property (rd_idx == cbcr_pkg::IDX_OVR_HI |=>
        (rd_data & ~cbcr_pkg::OVR_HI_MASK) == 8'h00)
        else $error("high mask reserved bits not zero");
    a_force_on: assert property (sideband_enable_pin |=> (sb_allow & $past(r_q.ovr)) == $past(r_q.ovr))
        else $error("masked output not forced on");
    a_mask_idle: assert property (!sideband_enable_pin |=> sb_allow == ~$past(sb_disable))
        else $error("mask acted while side-band disabled");
    a_imp_decode: assert property (##1 imp_trim_down[4] == ($past(r_q.imp[9:8]) == cbcr_pkg::IMP_LOWER)
        && imp_trim_up[4] == ($past(r_q.imp[9:8]) == cbcr_pkg::IMP_HIGHER))
        else $error("impedance code decoded wrongly");
    a_imp_top_resv: assert property (rd_idx == cbcr_pkg::IDX_IMP_TOP |=>
        (rd_data & ~cbcr_pkg::IMP_TOP_MASK) == 8'h00)
        else $error("top impedance reserved bits set");
    a_imp_next_resv: assert property (rd_idx == cbcr_pkg::IDX_IMP_NEXT |=>
        (rd_data & ~cbcr_pkg::IMP_NEXT_MASK) == 8'h00)
        else $error("next impedance reserved bits set");
endmodule // cbcr_regs

// ---- verification/cbcr_host_model.sv ----
// bus host on the far side: open-drain, released data line reads high via pull-up
module cbcr_host_model (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // data moves mid-low and is read mid-high; phases of 7-8 mclk cover prefetch
    task automatic xfer_bit(input logic b, output logic r);
        @(posedge mclk) scl <= 1'b0;
        wait_clk(3);
        sda_pull <= ~b;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        r = sda_line;
        wait_clk(3);
    endtask

    // also serves as repeated start after any byte acked in a write
    task automatic start_cond;
        @(posedge mclk) scl <= 1'b0;
        wait_clk(3);
        sda_pull <= 1'b0;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_pull <= 1'b1;
        wait_clk(4);
    endtask

    // host may end a transfer after any byte of a write, or after a nacked read byte
    task automatic stop_cond;
        @(posedge mclk) scl <= 1'b0;
        wait_clk(3);
        sda_pull <= 1'b1;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_pull <= 1'b0;
        wait_clk(4);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    // last byte is nacked so the device lets go of the line
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(last, r);
    endtask
endmodule // cbcr_host_model

// ---- verification/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0] DEV_ADDR = {4'hd, 3'h5};
    logic mclk, rstn, scl, sda_pull, sda_o, sda_oe_n, sda_w, sideband_enable_pin;
    logic [19:0] sb_disable, sb_allow;
    logic [4:0] imp_trim_down, imp_trim_up;
    logic [2:0] addr_sel;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] q[$];

    // wired-and of both open-drain parties, pull-up when released
    assign sda_w = ~sda_pull & (sda_oe_n | sda_o);

    cbcr_top dut_u (.mclk(mclk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .address_select_pin(addr_sel), .sideband_enable_pin(sideband_enable_pin),
        .sb_disable(sb_disable), .sb_allow(sb_allow), .imp_trim_down(imp_trim_down),
        .imp_trim_up(imp_trim_up));
    cbcr_host_model host_u (.mclk(mclk), .sda_line(sda_w), .scl(scl), .sda_pull(sda_pull));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmp_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
        check(32'(got.size()), 32'(exp.size()));
        foreach (exp[i]) check(32'(got[i]), 32'(exp[i]));
    endtask

    // let the one-cycle output register catch up, then sample clear of the edge
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // bytes past the count must be nacked
    task automatic wr_block(input logic [7:0] idx, input logic [7:0] cnt, input logic [7:0] d[$]);
        logic ack;
        host_u.start_cond();
        host_u.put_byte({DEV_ADDR, 1'b0}, ack);
        check(32'(ack), 32'h1);
        host_u.put_byte(idx, ack);
        host_u.put_byte(cnt, ack);
        foreach (d[i]) begin
            host_u.put_byte(d[i], ack);
            check(32'(ack), 32'(i < cnt));
        end
        host_u.stop_cond();
    endtask

    task automatic rd_block(input logic [7:0] idx, input int n, output logic [7:0] r[$]);
        logic ack;
        logic [7:0] b;
        r = {};
        host_u.start_cond();
        host_u.put_byte({DEV_ADDR, 1'b0}, ack);
        host_u.put_byte(idx, ack);
        host_u.start_cond();
        host_u.put_byte({DEV_ADDR, 1'b1}, ack);
        check(32'(ack), 32'h1);
        for (int i = 0; i < n; i++) begin
            host_u.get_byte(i == n - 1, b);
            r.push_back(b);
        end
        host_u.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        // pin moves after the latch; every later frame must still answer to 5
        addr_sel <= 3'h2;
        settle();
        check(32'(sb_allow), 32'hfffff);
        check(32'({imp_trim_down, imp_trim_up}), 32'h0);
        rd_block(8'h07, 9, q);
        cmp_q(q, '{8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    endtask

    task automatic t_masks;
        wr_block(8'h08, 8'h05, '{8'ha5, 8'h3c, 8'hff, 8'hff, 8'hff});
        settle();
        check(32'({imp_trim_down, imp_trim_up}), 32'h0);
        rd_block(8'h08, 9, q);
        cmp_q(q, '{8'h08, 8'ha5, 8'h3c, 8'h0f, 8'hdb, 8'h6c, 8'h00, 8'h00, 8'h00});
        @(posedge mclk);
        sb_disable <= 20'hfffff;
        settle();
        check(32'(sb_allow), 32'h0);
        @(posedge mclk);
        sideband_enable_pin <= 1'b1;
        settle();
        check(32'(sb_allow), 32'hf3ca5);
        @(posedge mclk);
        sb_disable <= 20'h0ff00;
        settle();
        check(32'(sb_allow), 32'hf3cff);
        @(posedge mclk);
        sb_disable <= 20'h0;
        sideband_enable_pin <= 1'b0;
    endtask

    task automatic t_imp;
        // out19 lower, out18 higher, out17 nominal; out16 higher, out15 lower
        wr_block(8'h0b, 8'h02, '{8'h50, 8'h44});
        settle();
        check(32'(imp_trim_down), 32'h11);
        check(32'(imp_trim_up), 32'h0a);
    endtask

    task automatic t_len;
        wr_block(8'h07, 8'h01, '{8'he3});
        rd_block(8'h08, 5, q);
        cmp_q(q, '{8'h03, 8'ha5, 8'h3c, 8'h0f, 8'hff});
        wr_block(8'h08, 8'h03, '{8'h11});
        wr_block(8'h09, 8'h01, '{8'h77, 8'h66});
        rd_block(8'h08, 4, q);
        cmp_q(q, '{8'h03, 8'h11, 8'h77, 8'h0f});
    endtask

    task automatic t_foreign;
        logic ack;
        host_u.start_cond();
        host_u.put_byte({4'hd, 3'h2, 1'b0}, ack);
        check(32'(ack), 32'h0);
        host_u.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        sideband_enable_pin = 1'b0;
        sb_disable = 20'h0;
        addr_sel = 3'h5;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_masks();
        t_imp();
        t_len();
        t_foreign();
        tally_and_finish();
    end

    // about 9.3k cycles expected; generous margin
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb_top
